// [agm_address_generator.sv]
module agm_address_generator
    import agm_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic                                     clk_sys,
    input  wire logic                                     resetn,
    // avalon-mm register slave
    input  wire logic [4:0]                               avs_address,
    input  wire logic                                     avs_read,
    input  wire logic                                     avs_write,
    input  wire logic [31:0]                              avs_writedata,
    input  wire logic [3:0]                               avs_byteenable,
    output logic      [31:0]                              avs_readdata,
    output logic                                          avs_waitrequest,
    // requests from the decoder, slot 0 x read, 1 x write, 2 y read
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0]          req_valid,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0][6:0]     req_mode,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0]          req_mac,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0][3:0]     req_ptr_sel,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0][15:0]    req_ptr_val,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0][15:0]    req_literal,
    input  wire logic [agm_pkg::AGM_NUM_GEN-1:0][15:0]    req_modify,
    // offset register values: [0] shared by x read and x write, [1] y
    input  wire logic [1:0][15:0]                         offset_reg_val,
    // results, one cycle after the request
    output logic      [agm_pkg::AGM_NUM_GEN-1:0]          ea_valid,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0][15:0]    ea,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0]          ea_direct,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0]          ea_error,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0]          wb_en,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0][3:0]     wb_sel,
    output logic      [agm_pkg::AGM_NUM_GEN-1:0][15:0]    wb_val
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (DATA_W != 16) begin : g_bad_width
        $error("agm_address_generator supports only a 16-bit data path");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [15:0]                         control;
        logic [15:0]                         x_start;
        logic [15:0]                         x_end;
        logic [15:0]                         y_start;
        logic [15:0]                         y_end;
        logic                                ack;
        logic [31:0]                         rdata;
        logic [AGM_NUM_GEN-1:0]              valid;
        logic [AGM_NUM_GEN-1:0][15:0]        ea;
        logic [AGM_NUM_GEN-1:0]              direct;
        logic [AGM_NUM_GEN-1:0]              error;
        logic [AGM_NUM_GEN-1:0]              wb_en;
        logic [AGM_NUM_GEN-1:0][3:0]         wb_sel;
        logic [AGM_NUM_GEN-1:0][15:0]        wb_val;
    } agm_state_s;

    agm_state_s state;
    agm_state_s next_state;

    // per-generator combinational results
    logic [AGM_NUM_GEN-1:0]       g_direct;
    logic [AGM_NUM_GEN-1:0]       g_error;
    logic [AGM_NUM_GEN-1:0]       g_wb_en;
    logic [AGM_NUM_GEN-1:0][15:0] g_ea;
    logic [AGM_NUM_GEN-1:0][15:0] g_wb_val;

    // circular enables per space
    logic                         x_circ_on;
    logic                         y_circ_on;
    logic [3:0]                   x_circ_sel;
    logic [3:0]                   y_circ_sel;

    // ****************************************************************
    // circular wrap: compare against limits, never for equality
    // ****************************************************************
    function automatic logic [15:0] agm_wrap(input logic [15:0] addr,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [15:0] len;
        len = 16'(hi - lo + 16'h0001);           // length implied by limits
        if (addr > hi) begin
            agm_wrap = 16'(addr - len);
        end else if (addr < lo) begin
            agm_wrap = 16'(addr + len);
        end else begin
            agm_wrap = addr;
        end
    endfunction

    // ****************************************************************
    // circular enables from the control register
    // ****************************************************************
    assign x_circ_sel = state.control[AGM_XSEL_LSB +: 4];
    assign y_circ_sel = state.control[AGM_YSEL_LSB +: 4];
    assign x_circ_on  = state.control[AGM_XEN_BIT] && (x_circ_sel != AGM_SEL_OFF);
    assign y_circ_on  = state.control[AGM_YEN_BIT] && (y_circ_sel != AGM_SEL_OFF);

    // ****************************************************************
    // the three generators: x read, x write, y read
    // ****************************************************************
    for (genvar g = 0; g < AGM_NUM_GEN; g++) begin : g_gen
        localparam bit IS_Y = (g == AGM_GEN_YR);
        logic [15:0] ptr;
        logic [15:0] sum_mod;
        logic [15:0] sum_off;
        logic [15:0] lo;
        logic [15:0] hi;
        logic        circ;
        logic        mac_bad;
        logic [3:0]  sel;

        assign ptr     = req_ptr_val[g];
        assign sel     = req_ptr_sel[g];
        assign sum_mod = 16'(ptr + req_modify[g]);
        // x read and x write take the same shared offset register value
        assign sum_off = 16'(ptr + ((req_mode[g] == AGM_MODE_REG_OFF) ? offset_reg_val[IS_Y]
                                                                         : req_literal[g]));
        assign lo      = IS_Y ? state.y_start : state.x_start;
        assign hi      = IS_Y ? state.y_end : state.x_end;
        // one buffer per space, any pointer but 15 may be the circular one (select 15 is off)
        assign circ    = IS_Y ? (y_circ_on && sel == y_circ_sel)
                              : (x_circ_on && sel == x_circ_sel);

        // multiply_accumulate_class legality of pointer and mode
        always_comb begin
            mac_bad = 1'b0;
            if (IS_Y && !req_mac[g]) begin
                mac_bad = 1'b1;
            end else if (req_mac[g]) begin
                if (IS_Y ? (sel != AGM_PF_TEN && sel != AGM_PF_ELEVEN)
                         : (sel != AGM_PF_EIGHT && sel != AGM_PF_NINE)) begin
                    mac_bad = 1'b1;
                end
                if (g == AGM_GEN_XW) begin
                    mac_bad = 1'b1;
                end
                case (req_mode[g])
                    AGM_MODE_INDIRECT: ;
                    AGM_MODE_POST: begin
                        if (req_modify[g] != 16'h0002 && req_modify[g] != 16'h0004
                            && req_modify[g] != 16'h0006) begin
                            mac_bad = 1'b1;
                        end
                    end
                    AGM_MODE_REG_OFF: begin
                        if (sel != (IS_Y ? AGM_PF_ELEVEN : AGM_PF_NINE)) begin
                            mac_bad = 1'b1;
                        end
                    end
                    default: mac_bad = 1'b1;
                endcase
            end
        end

        // effective address and pointer write-back per mode
        always_comb begin
            g_ea[g]     = 16'h0000;
            g_wb_val[g] = ptr;
            g_wb_en[g]  = 1'b0;
            g_direct[g] = 1'b0;
            g_error[g]  = mac_bad;
            case (req_mode[g])
                AGM_MODE_FILE: begin
                    g_ea[g] = {3'h0, req_literal[g][AGM_FILE_ADDR_W-1:0]};
                    g_error[g] = mac_bad || (IS_Y == 1'b1);
                end
                AGM_MODE_DIRECT: begin
                    g_direct[g] = 1'b1;
                end
                AGM_MODE_INDIRECT: begin
                    g_ea[g] = ptr;
                end
                AGM_MODE_POST: begin
                    g_ea[g]     = ptr;
                    g_wb_val[g] = circ ? agm_wrap(sum_mod, lo, hi) : sum_mod;
                    g_wb_en[g]  = 1'b1;
                end
                AGM_MODE_PRE: begin
                    g_ea[g]     = circ ? agm_wrap(sum_mod, lo, hi) : sum_mod;
                    g_wb_val[g] = g_ea[g];
                    g_wb_en[g]  = 1'b1;
                end
                AGM_MODE_REG_OFF, AGM_MODE_LIT_OFF: begin
                    g_ea[g] = circ ? agm_wrap(sum_off, lo, hi) : sum_off;
                end
                default: begin
                    g_error[g] = 1'b1;
                end
            endcase
            // y circular addresses are word aligned
            if (IS_Y && circ) begin
                g_ea[g][0]     = 1'b0;
                g_wb_val[g][0] = 1'b0;
            end
            if (g_error[g]) begin
                g_wb_en[g] = 1'b0;
            end
        end
    end

    // ****************************************************************
    // next state: register slave and result capture
    // ****************************************************************
    always_comb begin
        logic [15:0] wdat;
        logic        lo_en;
        logic        hi_en;
        next_state  = state;
        wdat        = avs_writedata[15:0];
        lo_en       = avs_byteenable[0];
        hi_en       = avs_byteenable[1];
        next_state.ack   = (avs_read || avs_write) && !state.ack;
        // a write lands on the single accepting edge
        if (avs_write && state.ack) begin
            case (avs_address)
                AGM_OFF_CONTROL: begin
                    if (lo_en) next_state.control[7:0]  = wdat[7:0] & AGM_CONTROL_MASK[7:0];
                    if (hi_en) next_state.control[15:8] = wdat[15:8] & AGM_CONTROL_MASK[15:8];
                end
                AGM_OFF_X_START: begin
                    if (lo_en) next_state.x_start[7:0]  = {wdat[7:1], 1'b0};
                    if (hi_en) next_state.x_start[15:8] = wdat[15:8];
                end
                AGM_OFF_X_END: begin
                    if (lo_en) next_state.x_end[7:0]  = {wdat[7:1], 1'b1};
                    if (hi_en) next_state.x_end[15:8] = wdat[15:8];
                end
                AGM_OFF_Y_START: begin
                    if (lo_en) next_state.y_start[7:0]  = {wdat[7:1], 1'b0};
                    if (hi_en) next_state.y_start[15:8] = wdat[15:8];
                end
                AGM_OFF_Y_END: begin
                    if (lo_en) next_state.y_end[7:0]  = {wdat[7:1], 1'b1};
                    if (hi_en) next_state.y_end[15:8] = wdat[15:8];
                end
                default: ;
            endcase
        end
        // read data prepared on the first cycle, stands at the accepting edge
        if (avs_read && !state.ack) begin
            case (avs_address)
                AGM_OFF_CONTROL: next_state.rdata = {16'h0000, state.control};
                AGM_OFF_X_START: next_state.rdata = {16'h0000, state.x_start};
                AGM_OFF_X_END:   next_state.rdata = {16'h0000, state.x_end};
                AGM_OFF_Y_START: next_state.rdata = {16'h0000, state.y_start};
                AGM_OFF_Y_END:   next_state.rdata = {16'h0000, state.y_end};
                default:         next_state.rdata = 32'h0000_0000;
            endcase
        end
        // generator results, one cycle after each request
        next_state.valid  = req_valid;
        next_state.ea     = g_ea;
        next_state.direct = g_direct & req_valid;
        next_state.error  = g_error & req_valid;
        next_state.wb_en  = g_wb_en & req_valid;
        next_state.wb_sel = req_ptr_sel;
        next_state.wb_val = g_wb_val;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state         <= '0;
            state.control <= AGM_RST_CONTROL;
            state.x_start <= AGM_RST_START;
            state.x_end   <= AGM_RST_END;
            state.y_start <= AGM_RST_START;
            state.y_end   <= AGM_RST_END;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
    assign avs_readdata    = state.rdata;
    assign ea_valid        = state.valid;
    assign ea              = state.ea;
    assign ea_direct       = state.direct;
    assign ea_error        = state.error;
    assign wb_en           = state.wb_en;
    assign wb_sel          = state.wb_sel;
    assign wb_val          = state.wb_val;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_x_disable_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
        (x_circ_sel == AGM_SEL_OFF) |-> !x_circ_on)
        else $error("x circular active with select 15");

    chk_y_enable_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
        !state.control[AGM_YEN_BIT] |-> !y_circ_on)
        else $error("y circular active without enable");

    chk_x_enable_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
        x_circ_on |-> (state.control[AGM_XEN_BIT] && x_circ_sel != AGM_SEL_OFF))
        else $error("x circular active without its conditions");

    chk_offset_no_wb: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[0] && (req_mode[0] == AGM_MODE_REG_OFF || req_mode[0] == AGM_MODE_LIT_OFF))
        |=> !wb_en[0])
        else $error("offset mode wrote the pointer back");

    chk_post_ea_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[0] && req_mode[0] == AGM_MODE_POST && !req_mac[0])
        |=> (ea[0] == $past(req_ptr_val[0]) && wb_en[0]))
        else $error("post-modify did not use pointer first");

    chk_pre_ea_wb: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[1] && req_mode[1] == AGM_MODE_PRE)
        |=> (wb_en[1] && wb_val[1] == ea[1]))
        else $error("pre-modify write-back differs from address");

    chk_y_word_align: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[2] && y_circ_on && req_ptr_sel[2] == y_circ_sel) |=> !ea[2][0])
        else $error("y circular address has bit zero set");

    chk_y_mac_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[2] && !req_mac[2]) |=> (ea_error[2] && !wb_en[2]))
        else $error("y generator served a non mac request");

    chk_mac_ptr_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[0] && req_mac[0] && req_ptr_sel[0] != AGM_PF_EIGHT
         && req_ptr_sel[0] != AGM_PF_NINE) |=> ea_error[0])
        else $error("x mac read accepted pointer outside eight and nine");

    chk_wrap_inside: assert property (@(posedge clk_sys) disable iff (!resetn)
        (req_valid[0] && req_mode[0] == AGM_MODE_PRE && x_circ_on && req_ptr_sel[0] == x_circ_sel
         && state.x_end > state.x_start && req_ptr_val[0] >= state.x_start
         && req_ptr_val[0] <= state.x_end && req_modify[0] <= 16'h0002)
        |=> (ea[0] >= $past(state.x_start) && ea[0] <= $past(state.x_end)))
        else $error("circular address left its buffer");

    chk_bus_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        (avs_read && !state.ack) |=> (state.ack && !avs_waitrequest))
        else $error("bus answer not given on second cycle");

endmodule

// [agm_address_generator_tb_top.sv]
// ****************************************************************
// self-checking bench for the address generator
// ****************************************************************
module agm_address_generator_tb_top;
    import agm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic [15:0] ea; logic en; logic [15:0] wv; logic er; } agm_exp_s;
    localparam agm_exp_s ERR = '{16'h0000, 1'b0, 16'h0000, 1'b1};
    logic             clk_sys = 1'b0;
    logic             resetn = 1'b0;
    logic [4:0]       avs_address = '0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = '0;
    logic [3:0]       avs_byteenable = 4'h3;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [2:0]       req_valid = '0;
    logic [2:0][6:0]  req_mode = '0;
    logic [2:0]       req_mac = '0;
    logic [2:0][3:0]  req_ptr_sel = '0;
    logic [2:0][15:0] req_ptr_val = '0;
    logic [2:0][15:0] req_literal = '0;
    logic [2:0][15:0] req_modify = '0;
    logic [1:0][15:0] offset_reg_val = '0;
    logic [2:0]       ea_valid, ea_direct, ea_error, wb_en;
    logic [2:0][3:0]  wb_sel;
    logic [2:0][15:0] ea, wb_val;
    logic [15:0][15:0] w;
    logic [31:0]      r = 32'h687aac7c;
    agm_exp_s         q[$];
    agm_exp_s         x;
    int               errors = 0;
    int               compares = 0;
    agm_address_generator agm_address_generator_i (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .req_valid, .req_mode, .req_mac,
        .req_ptr_sel, .req_ptr_val, .req_literal, .req_modify, .offset_reg_val, .ea_valid, .ea, .ea_direct,
        .ea_error, .wb_en, .wb_sel, .wb_val);
    agm_regfile_model agm_regfile_model_i (.clk_sys, .resetn, .wb_en, .wb_sel, .wb_val, .w);
    // clock at 25 mhz
    always #20 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        if (!wr) check(avs_readdata[15:0], d);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // one generator request; the expectation is queued for the watcher
    task automatic gen(input int s, input agm_mode_e m, input logic mc, input logic [3:0] p,
                       input logic [15:0] pv, input logic [15:0] md, input agm_exp_s e);
        @(posedge clk_sys);
        req_valid[s] <= 1'b1;
        req_mode[s] <= m;
        req_mac[s] <= mc;
        req_ptr_sel[s] <= p;
        req_ptr_val[s] <= pv;
        req_literal[s] <= md;
        req_modify[s] <= md;
        q.push_back(e);
        @(posedge clk_sys);
        req_valid[s] <= 1'b0;
    endtask
    // watcher: compare each result with the oldest expectation
    always @(negedge clk_sys) begin
        for (int s = 0; s < 3; s++) begin
            if (ea_valid[s] === 1'b1) begin
                x = q.pop_front();
                check(ea_error[s], x.er);
                check(wb_en[s], x.en);
                if (!x.er) check(ea[s], x.ea);
                if (x.en) check(wb_val[s], x.wv);
            end
        end
    end
    // watchdog
    initial begin
        #400000;
        errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(1'b0, AGM_OFF_CONTROL, AGM_RST_CONTROL);
        bus(1'b0, AGM_OFF_X_END, AGM_RST_END);
        bus(1'b0, 5'h14, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            offset_reg_val[0] <= r[31:16];
            gen(0, AGM_MODE_INDIRECT, 1'b0, 4'h1, r[15:0], 16'h0000, '{r[15:0], 1'b0, 16'h0000, 1'b0});
            gen(0, AGM_MODE_POST, 1'b0, 4'h2, r[15:0], r[31:16], '{r[15:0], 1'b1, r[15:0] + r[31:16], 1'b0});
            gen(1, AGM_MODE_PRE, 1'b0, 4'h2, r[15:0], r[31:16], '{r[15:0] + r[31:16], 1'b1, r[15:0] + r[31:16], 1'b0});
            gen(1, AGM_MODE_REG_OFF, 1'b0, 4'h5, r[15:0], 16'h0000, '{r[15:0] + r[31:16], 1'b0, 16'h0000, 1'b0});
            gen(0, AGM_MODE_LIT_OFF, 1'b0, 4'h6, r[31:16], r[15:0], '{r[15:0] + r[31:16], 1'b0, 16'h0000, 1'b0});
        end
        gen(0, AGM_MODE_FILE, 1'b0, 4'h0, 16'h0000, 16'hffff, '{16'h1fff, 1'b0, 16'h0000, 1'b0});
        gen(0, AGM_MODE_DIRECT, 1'b0, 4'h4, 16'h0000, 16'h0000, '{16'h0000, 1'b0, 16'h0000, 1'b0});
        @(negedge clk_sys);
        check(ea_direct[0], 1'b1);
        bus(1'b1, AGM_OFF_X_START, 16'h1000);
        bus(1'b1, AGM_OFF_X_END, 16'h100f);
        bus(1'b1, AGM_OFF_CONTROL, 16'h8003);
        offset_reg_val[0] <= 16'h000a;
        gen(0, AGM_MODE_POST, 1'b0, 4'h3, 16'h100e, 16'h0004, '{16'h100e, 1'b1, 16'h1002, 1'b0});
        @(posedge clk_sys);
        @(negedge clk_sys);
        check(w[3], 16'h1002);
        gen(1, AGM_MODE_REG_OFF, 1'b0, 4'h3, 16'h1008, 16'h0000, '{16'h1002, 1'b0, 16'h0000, 1'b0});
        gen(0, AGM_MODE_PRE, 1'b0, 4'h3, 16'h1000, 16'hfffe, '{16'h100e, 1'b1, 16'h100e, 1'b0});
        gen(0, AGM_MODE_PRE, 1'b0, 4'h3, 16'h100e, 16'h0002, '{16'h1000, 1'b1, 16'h1000, 1'b0});
        bus(1'b1, AGM_OFF_CONTROL, 16'h800f);
        gen(0, AGM_MODE_POST, 1'b0, 4'hf, 16'h100e, 16'h0004, '{16'h100e, 1'b1, 16'h1012, 1'b0});
        bus(1'b1, AGM_OFF_Y_START, 16'h2000);
        bus(1'b1, AGM_OFF_Y_END, 16'h200f);
        bus(1'b1, AGM_OFF_CONTROL, 16'h40b0);
        offset_reg_val[1] <= 16'h0008;
        gen(2, AGM_MODE_POST, 1'b1, 4'hb, 16'h200e, 16'h0002, '{16'h200e, 1'b1, 16'h2000, 1'b0});
        gen(2, AGM_MODE_REG_OFF, 1'b1, 4'hb, 16'h2003, 16'h0000, '{16'h200a, 1'b0, 16'h0000, 1'b0});
        gen(0, AGM_MODE_POST, 1'b1, 4'h8, 16'h0100, 16'h0006, '{16'h0100, 1'b1, 16'h0106, 1'b0});
        gen(0, AGM_MODE_INDIRECT, 1'b1, 4'ha, 16'h0100, 16'h0000, ERR);
        gen(0, AGM_MODE_REG_OFF, 1'b1, 4'h8, 16'h0100, 16'h0000, ERR);
        gen(0, AGM_MODE_PRE, 1'b1, 4'h8, 16'h0100, 16'h0002, ERR);
        gen(0, AGM_MODE_POST, 1'b1, 4'h8, 16'h0100, 16'h0008, ERR);
        gen(2, AGM_MODE_INDIRECT, 1'b0, 4'ha, 16'h0100, 16'h0000, ERR);
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
endmodule

// [agm_pkg.sv]
package agm_pkg;

    // ****************************************************************
    // register map (byte addresses on the avalon slave)
    // ****************************************************************
    localparam logic [4:0]  AGM_OFF_CONTROL  = 5'h00;
    localparam logic [4:0]  AGM_OFF_X_START  = 5'h04;
    localparam logic [4:0]  AGM_OFF_X_END    = 5'h08;
    localparam logic [4:0]  AGM_OFF_Y_START  = 5'h0c;
    localparam logic [4:0]  AGM_OFF_Y_END    = 5'h10;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int          AGM_XSEL_LSB     = 0;
    localparam int          AGM_YSEL_LSB     = 4;
    localparam int          AGM_BSEL_LSB     = 8;
    localparam int          AGM_YEN_BIT      = 14;
    localparam int          AGM_XEN_BIT      = 15;
    localparam logic [15:0] AGM_CONTROL_MASK = 16'hcfff;
    localparam logic [3:0]  AGM_SEL_OFF      = 4'hf;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] AGM_RST_CONTROL  = 16'h0000;
    localparam logic [15:0] AGM_RST_START    = 16'h0000;
    localparam logic [15:0] AGM_RST_END      = 16'h0001;

    // ****************************************************************
    // generator slots and working register numbers
    // ****************************************************************
    localparam int          AGM_GEN_XR       = 0;
    localparam int          AGM_GEN_XW       = 1;
    localparam int          AGM_GEN_YR       = 2;
    localparam int          AGM_NUM_GEN      = 3;
    localparam logic [3:0]  AGM_PF_EIGHT     = 4'h8;
    localparam logic [3:0]  AGM_PF_NINE      = 4'h9;
    localparam logic [3:0]  AGM_PF_TEN       = 4'ha;
    localparam logic [3:0]  AGM_PF_ELEVEN    = 4'hb;
    localparam int          AGM_FILE_ADDR_W  = 13;
    localparam int          AGM_LIT_W        = 5;

    // ****************************************************************
    // addressing modes, one-hot
    // ****************************************************************
    typedef enum logic [6:0] {
        AGM_MODE_FILE     = 7'h01,
        AGM_MODE_DIRECT   = 7'h02,
        AGM_MODE_INDIRECT = 7'h04,
        AGM_MODE_POST     = 7'h08,
        AGM_MODE_PRE      = 7'h10,
        AGM_MODE_REG_OFF  = 7'h20,
        AGM_MODE_LIT_OFF  = 7'h40
    } agm_mode_e;

endpackage

// [agm_regfile_model.sv]
// ****************************************************************
// working register file seen by the generators
// ****************************************************************
module agm_regfile_model (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // pointer write-back from the generators
    input  wire logic [2:0]        wb_en,
    input  wire logic [2:0][3:0]   wb_sel,
    input  wire logic [2:0][15:0]  wb_val,
    // register contents
    output logic      [15:0][15:0] w
);
    timeunit 1ns;
    timeprecision 1ns;
    // store write-backs; only pointer 15 is never picked as a circular pointer, since select 15 is off
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            w <= '0;
        end else begin
            for (int s = 0; s < 3; s++) begin
                if (wb_en[s]) begin
                    w[wb_sel[s]] <= wb_val[s];
                end
            end
        end
    end
endmodule
